// ===== rtl/overcurrent_guard.sv
// Overcurrent guard sequencer: power-on delay, trip-level sample, soft-start, hiccup retry.
// Assumes comparator and enable inputs come from pins and are synchronised here.
// Notes on behaviour
// - Trip turns gates off, two dummies, one try
// - Hiccup retries repeat without any limit
// - Fixed delay after reset before sampling
// - Sampling disables low gate, enables current source
// - Trip level held as DAC count
// - Monitoring starts after blanking from low edge
// - Monitoring ends when low pwm or forced pulse ends
// - Third narrow low pulse stretched to minimum
// - Guard disabled also disables pulse stretching
// - Drop compared against twice sampled setting
// - Trip range supported from zero upward
// - High or absent setting disables guard
// - Retry period between nominal minimum and maximum
// - Detection active during every soft-start ramp
// - Fault gone: finish ramp, then regulate
// - Resample only after reset or shutdown release
// - Ramp uses sixty-four equal steps
// - Sampling phase bounded by nominal maximum
module overcurrent_guard
  import guard_pkg::*;
#(
  parameter int unsigned DELAY_CYC  = POR_DELAY_CYC,
  parameter int unsigned SAMPLE_CYC = SAMPLE_MAX_CYC,
  parameter int unsigned STEP_LEN   = STEP_CYC
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     enable_pin_in,
  input  wire logic                     sample_above_in,
  input  wire logic                     trip_cmp_in,
  input  wire logic                     pwm_low_in,
  input  wire logic                     cycle_start_in,
  output logic                          low_side_gate_out,
  output logic                          high_side_gate_out,
  output logic                          source_en_out,
  output logic [guard_pkg::TRIP_BITS-1:0] trip_dac_out,
  output logic [5:0]                    ramp_step_out,
  output logic                          guard_off_out,
  output logic                          regulating_out
);
  import guard_pkg::*;

  localparam int unsigned DW = $clog2(DELAY_CYC + SAMPLE_CYC + STEP_LEN + 2);

  seq_state_type  state_q;
  logic [DW-1:0]  timer_q;
  logic [5:0]     step_q;
  logic [1:0]     dummy_q;
  logic [7:0]     dac_q;
  logic           guard_off_q;
  logic [1:0]     en_sync_q;
  logic [1:0]     above_sync_q;
  logic [1:0]     trip_sync_q;
  logic           en_s;
  logic           above_s;
  logic           trip_s;
  logic           step_tick;
  logic           run;
  logic           low_on;
  logic           window;
  logic           trip_hit;

  // Pin inputs pass two flops; only the second stage is read.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      en_sync_q    <= 2'h0;
      above_sync_q <= 2'h0;
      trip_sync_q  <= 2'h0;
    end else begin
      en_sync_q    <= {en_sync_q[0], enable_pin_in};
      above_sync_q <= {above_sync_q[0], sample_above_in};
      trip_sync_q  <= {trip_sync_q[0], trip_cmp_in};
    end
  end
  assign en_s    = en_sync_q[1];
  assign above_s = above_sync_q[1];
  assign trip_s  = trip_sync_q[1];

  // One ramp step elapses every STEP_LEN reference clocks, independent of switching.
  assign step_tick = (timer_q == DW'(STEP_LEN - 1));

  // The comparator reports drop above twice the DAC level; only inside the window counts.
  assign trip_hit = window && trip_s && !guard_off_q;

  assign run = (state_q == ST_RAMP) || (state_q == ST_RUN);

  // Main sequence. Shutdown always returns to the wait state and forces a fresh sample.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_WAIT;
      timer_q <= '0;
      step_q  <= 6'h00;
      dummy_q <= 2'h0;
    end else if (!en_s) begin
      state_q <= ST_WAIT;
      timer_q <= '0;
      step_q  <= 6'h00;
      dummy_q <= 2'h0;
    end else begin
      unique case (state_q)
        ST_WAIT: begin
          state_q <= ST_DELAY;
          timer_q <= '0;
        end
        ST_DELAY: begin
          if (timer_q == DW'(DELAY_CYC - 1)) begin
            state_q <= ST_SAMPLE;
            timer_q <= '0;
          end else begin
            timer_q <= timer_q + DW'(1);
          end
        end
        ST_SAMPLE: begin
          // The DAC climbs until it passes the pin voltage, reaches full scale or the time runs out.
          if (!above_s || dac_q == 8'hff || timer_q == DW'(SAMPLE_CYC - 1)) begin
            state_q <= ST_RAMP;
            timer_q <= '0;
            step_q  <= 6'h00;
          end else begin
            timer_q <= timer_q + DW'(1);
          end
        end
        ST_RAMP: begin
          if (trip_hit) begin
            state_q <= ST_DUMMY;
            timer_q <= '0;
            step_q  <= 6'h00;
            dummy_q <= 2'h0;
          end else if (step_tick) begin
            timer_q <= '0;
            if (step_q == STEP_LAST) begin
              state_q <= ST_RUN;
            end else begin
              step_q <= step_q + 6'h01;
            end
          end else begin
            timer_q <= timer_q + DW'(1);
          end
        end
        ST_RUN: begin
          if (trip_hit) begin
            state_q <= ST_DUMMY;
            timer_q <= '0;
            step_q  <= 6'h00;
            dummy_q <= 2'h0;
          end
        end
        ST_DUMMY: begin
          // Each dummy time-out is one full ramp length with the gates held off.
          if (step_tick) begin
            timer_q <= '0;
            if (step_q == STEP_LAST) begin
              step_q <= 6'h00;
              if (dummy_q == 2'(DUMMY_COUNT - 1)) begin
                state_q <= ST_RAMP;
                dummy_q <= 2'h0;
              end else begin
                dummy_q <= dummy_q + 2'h1;
              end
            end else begin
              step_q <= step_q + 6'h01;
            end
          end else begin
            timer_q <= timer_q + DW'(1);
          end
        end
      endcase
    end
  end

  // Trip level counter: kept across retries, replaced only by a new sample.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dac_q <= TRIP_RESET;
    end else if (state_q == ST_DELAY && en_s) begin
      dac_q <= TRIP_RESET;
    end else if (state_q == ST_SAMPLE && above_s && dac_q != 8'hff) begin
      dac_q <= dac_q + 8'h01;
    end
  end

  // Guard-off flag is decided once at the end of sampling; an open resistor reads full scale.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      guard_off_q <= 1'b0;
    end else if (state_q == ST_SAMPLE && en_s &&
                 (!above_s || dac_q == 8'hff || timer_q == DW'(SAMPLE_CYC - 1))) begin
      guard_off_q <= (dac_q > TRIP_DISABLE) || above_s;
    end
  end

  low_pulse_stretch #(
    .MIN_CYC (MIN_PULSE_CYC),
    .BLANK   (BLANK_CYC),
    .LIMIT   (NARROW_LIMIT)
  ) u_stretch (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n_in),
    .run_in         (run), // Trip gating stays at the outputs, since the window feeds the trip.
    .stretch_en_in  (!guard_off_q),
    .pwm_low_in     (pwm_low_in),
    .cycle_start_in (cycle_start_in),
    .low_on_out     (low_on),
    .window_out     (window)
  );

  // Gate outputs: both off immediately on a trip and outside the run states.
  // High side is held off whenever the low side is on so the gates never overlap.
  assign low_side_gate_out  = low_on && !trip_hit && (state_q != ST_SAMPLE);
  assign high_side_gate_out = run && !trip_hit && !low_on && !pwm_low_in;

  assign source_en_out  = (state_q == ST_SAMPLE) || (state_q == ST_DELAY);
  assign trip_dac_out   = dac_q;
  assign ramp_step_out  = (state_q == ST_RUN) ? STEP_LAST : ((state_q == ST_RAMP) ? step_q : 6'h00);
  assign guard_off_out  = guard_off_q;
  assign regulating_out = (state_q == ST_RUN);
endmodule

// ===== rtl/guard_pkg.sv
// Constants shared by the overcurrent guard sequencer and its pulse stretcher.
// Assumes a single 25 MHz timing clock that does not depend on the switching frequency.
package guard_pkg;
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned POR_DELAY_US   = 6800;
  localparam int unsigned POR_DELAY_CYC  = POR_DELAY_US * (CLK_HZ / 1000000);
  localparam int unsigned SAMPLE_MAX_US  = 3400;
  localparam int unsigned SAMPLE_MAX_CYC = SAMPLE_MAX_US * (CLK_HZ / 1000000);
  localparam int unsigned RAMP_US        = 6800;
  localparam int unsigned RAMP_STEPS     = 64;
  localparam int unsigned STEP_CYC       = (RAMP_US * (CLK_HZ / 1000000)) / RAMP_STEPS;
  localparam int unsigned BLANK_NS       = 200;
  localparam int unsigned BLANK_CYC      = (BLANK_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned MIN_PULSE_NS   = 425;
  localparam int unsigned MIN_PULSE_CYC  = (MIN_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned NARROW_LIMIT   = 3;
  localparam int unsigned DUMMY_COUNT    = 2;
  localparam int unsigned TRIP_BITS      = 8;
  localparam logic [7:0]  TRIP_RESET     = 8'h00;
  // Sampled setting above 0.3 V disables the guard; 475 mV is full scale at 0xff.
  localparam logic [7:0]  TRIP_DISABLE   = 8'ha1;
  localparam logic [5:0]  STEP_LAST      = 6'h3f;
  typedef enum logic [5:0] {
    ST_WAIT    = 6'b000001,
    ST_DELAY   = 6'b000010,
    ST_SAMPLE  = 6'b000100,
    ST_RAMP    = 6'b001000,
    ST_RUN     = 6'b010000,
    ST_DUMMY   = 6'b100000
  } seq_state_type;
endpackage

// ===== rtl/low_pulse_stretch.sv
// Low-side pulse stretcher/inserter with non-overlap and trip monitor window.
// Assumes pwm_low_in is synchronous to clk_in and high_side request is its inverse.
module low_pulse_stretch #(
  parameter int unsigned MIN_CYC   = 11,
  parameter int unsigned BLANK     = 5,
  parameter int unsigned LIMIT     = 3
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic run_in,
  input  wire logic stretch_en_in,
  input  wire logic pwm_low_in,
  input  wire logic cycle_start_in,
  output logic      low_on_out,
  output logic      window_out
);
  localparam int unsigned CW = $clog2(MIN_CYC + BLANK + 2);
  logic [CW-1:0] width_q;
  logic [1:0]    narrow_q;
  logic          force_q;
  logic          pwm_d1_q;
  logic          low_wide;

  // The count is valid only once the pulse has been high for a cycle. Before that it still
  // holds the previous pulse, which must neither open the window nor end a forced pulse.
  assign low_wide = pwm_d1_q && (width_q >= CW'(MIN_CYC));

  // Width of the current low-side pulse, reset on each rising low-side edge.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      width_q  <= '0;
      pwm_d1_q <= 1'b0;
    end else begin
      pwm_d1_q <= low_on_out;
      if (low_on_out && !pwm_d1_q) begin
        width_q <= CW'(1);
      end else if (low_on_out && !low_wide) begin
        width_q <= width_q + CW'(1);
      end else if (!low_on_out) begin
        width_q <= width_q;
      end
    end
  end

  // Count narrow cycles; the third one is forced to minimum width.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !run_in || !stretch_en_in) begin
      narrow_q <= 2'h0;
      force_q  <= 1'b0;
    end else if (cycle_start_in) begin
      if (force_q || pwm_low_in && low_wide) begin
        narrow_q <= 2'h0;
      end else if (narrow_q == 2'(LIMIT - 1)) begin
        narrow_q <= 2'h0;
        force_q  <= 1'b1;
      end else begin
        narrow_q <= narrow_q + 2'h1;
      end
      if (force_q) begin
        force_q <= 1'b0;
      end
    end else if (force_q && low_wide) begin
      force_q <= 1'b0;
    end
  end

  // Forced pulse holds the low gate until minimum width; the high gate sees it as on and stays off.
  assign low_on_out = run_in && (pwm_low_in || force_q);
  assign window_out = low_on_out && pwm_d1_q && (width_q > CW'(BLANK));
endmodule

// ===== verif/guard_asserts.sv
// Port checker for the overcurrent guard sequencer.
// Assumes it is bound onto overcurrent_guard with the same timing parameters.
module guard_asserts #(
  parameter int unsigned DELAY_CYC  = 20,
  parameter int unsigned SAMPLE_CYC = 300,
  parameter int unsigned STEP_LEN   = 4
) (
  input wire logic                          clk_in,
  input wire logic                          rst_n_in,
  input wire logic                          low_side_gate_out,
  input wire logic                          high_side_gate_out,
  input wire logic                          source_en_out,
  input wire logic [guard_pkg::TRIP_BITS-1:0] trip_dac_out,
  input wire logic [5:0]                    ramp_step_out,
  input wire logic                          guard_off_out,
  input wire logic                          regulating_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] gap_q;
  logic [15:0] src_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Cycles out of regulation and with the source on; runs are short, so no saturation.
  always_ff @(posedge clk_in) begin
    gap_q <= (!rst_n_in || regulating_out) ? 16'h0000 : gap_q + 16'h0001;
    src_q <= (!rst_n_in || !source_en_out) ? 16'h0000 : src_q + 16'h0001;
  end
  chk_gates_apart: assert property (!(low_side_gate_out && high_side_gate_out))
    else $error("both gates on together");
  chk_sample_low_off: assert property (source_en_out |-> !low_side_gate_out)
    else $error("low gate on while sampling");
  chk_trip_gates_off: assert property ($fell(regulating_out) |-> (!low_side_gate_out && !high_side_gate_out)[*8])
    else $error("gates not off after leaving regulation");
  chk_run_full_step: assert property (regulating_out |-> ramp_step_out == 6'h3f)
    else $error("regulating below last step");
  chk_step_walk: assert property ($changed(ramp_step_out) |-> ramp_step_out == $past(ramp_step_out) + 6'h01 || ramp_step_out == 6'h00)
    else $error("ramp step skipped");
  chk_step_hold: assert property ($changed(ramp_step_out) && ramp_step_out != 6'h00 |=> ($stable(ramp_step_out) || ramp_step_out == 6'h00)[*3])
    else $error("ramp step too short");
  chk_dac_hold: assert property (regulating_out |=> $stable(trip_dac_out))
    else $error("trip level changed in regulation");
  chk_guard_off_high: assert property ($fell(source_en_out) && trip_dac_out > 8'ha1 |=> guard_off_out)
    else $error("high setting left guard on");
  chk_sample_bound: assert property (src_q <= DELAY_CYC + SAMPLE_CYC + 4)
    else $error("sampling phase too long");
  chk_ramp_length: assert property ($rose(regulating_out) |-> gap_q >= 64 * STEP_LEN)
    else $error("regulation reached before a full ramp");
endmodule

// ===== verif/stage_model.sv
// Behavioural power stage and trip comparator on the far side of the guard.
// Assumes the bench sets the resistor level and whether the output is shorted.
module stage_model (
  input  wire logic       clk_in,
  input  wire logic       low_side_gate_in,
  input  wire logic       source_en_in,
  input  wire logic [7:0] trip_dac_in,
  input  wire logic [7:0] setting_in,
  input  wire logic       short_in,
  output logic            sample_above_out,
  output logic            trip_cmp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin voltage exceeds the DAC only while the source runs and the count lags.
  always_ff @(posedge clk_in) begin
    sample_above_out <= source_en_in && (setting_in > trip_dac_in);
  end
  // A short shows a drop above twice the setting only while the low switch conducts.
  always_ff @(posedge clk_in) begin
    trip_cmp_out <= short_in && low_side_gate_in;
  end
endmodule

// ===== verif/test_overcurrent_guard.sv
// Bench for the guard: start-up, hiccup retries, pulse stretching, disabled guard.
// Assumes small timing parameters so the whole run stays short.
module test_overcurrent_guard;
  timeunit 1ns;
  timeprecision 1ps;
  import guard_pkg::*;
  localparam int unsigned DELAY_CYC  = 20;
  localparam int unsigned SAMPLE_CYC = 300;
  localparam int unsigned STEP_LEN   = 4;
  logic       clk_in         = 1'b0;
  logic       rst_n_in       = 1'b0;
  logic       enable_pin_in  = 1'b1;
  logic       cycle_start_in = 1'b0;
  logic       pwm_low_in     = 1'b0;
  logic       short_q        = 1'b0;
  logic [7:0] setting_q      = 8'h40;
  logic       sample_above_in, trip_cmp_in, low_side_gate_out, high_side_gate_out;
  logic       source_en_out, guard_off_out, regulating_out;
  logic [7:0] trip_dac_out;
  logic [5:0] ramp_step_out;
  int         error_cnt = 0, samples_checked = 0, lw = 6, ph = 0;
  overcurrent_guard #(.DELAY_CYC(DELAY_CYC), .SAMPLE_CYC(SAMPLE_CYC), .STEP_LEN(STEP_LEN)) overcurrent_guard_inst (
    .clk_in, .rst_n_in, .enable_pin_in, .sample_above_in, .trip_cmp_in, .pwm_low_in, .cycle_start_in,
    .low_side_gate_out, .high_side_gate_out, .source_en_out, .trip_dac_out, .ramp_step_out,
    .guard_off_out, .regulating_out);
  stage_model stage_model_inst (.clk_in, .low_side_gate_in(low_side_gate_out), .source_en_in(source_en_out),
    .trip_dac_in(trip_dac_out), .setting_in(setting_q), .short_in(short_q),
    .sample_above_out(sample_above_in), .trip_cmp_out(trip_cmp_in));
  initial forever #20 clk_in = ~clk_in;
  // Switching pattern of 20 cycles, low-side request in the last lw+1 cycles, none when lw is 0.
  always @(posedge clk_in) begin
    ph <= (ph == 19) ? 0 : ph + 1;
    cycle_start_in <= (ph == 19);
    pwm_low_in <= (ph >= 19 - lw) && (lw > 0);
  end
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic compare(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait for regulation to reach a level; a timeout shows up as a mismatch.
  task automatic wait_reg(input logic val, input int lim);
    int n = 0;
    while (regulating_out !== val && n < lim) begin
      tick();
      n++;
    end
    compare({7'h0, regulating_out}, {7'h0, val});
  endtask
  // Off time before the low gate comes back must cover two dummies but not a third ramp.
  task automatic gap_check();
    int n = 0;
    while (low_side_gate_out !== 1'b1 && n < 1000) begin
      tick();
      n++;
    end
    compare({7'h0, n >= 128 * STEP_LEN && n < 192 * STEP_LEN}, 8'h01);
  endtask
  task automatic start_up(input logic [7:0] s);
    @(posedge clk_in);
    setting_q <= s;
    rst_n_in <= 1'b0;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    wait_reg(1'b1, 2000);
    compare({7'h0, trip_dac_out >= s && trip_dac_out <= s + 8'h03}, 8'h01);
    compare({7'h0, guard_off_out}, 8'h00);
  endtask
  task automatic hiccup();
    logic [7:0] held = trip_dac_out;
    int         n    = 0;
    @(posedge clk_in);
    lw <= 10;
    // Arm the short in the low-side off time, so that the trip lands on a whole pulse.
    repeat (40) tick();
    while (cycle_start_in !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    repeat (3) tick();
    @(posedge clk_in);
    short_q <= 1'b1;
    wait_reg(1'b0, 100);
    compare({7'h0, low_side_gate_out | high_side_gate_out}, 8'h00);
    gap_check();
    // The first ramp pulse into the short must be cut by a trip, not end on its own.
    n = 0;
    while (low_side_gate_out === 1'b1 && n < 40) begin
      tick();
      n++;
    end
    compare({7'h0, low_side_gate_out | high_side_gate_out}, 8'h00);
    gap_check();
    @(posedge clk_in);
    short_q <= 1'b0;
    wait_reg(1'b1, 1200);
    compare(trip_dac_out, held);
  endtask
  task automatic stretch(input int exp_min, input int exp_max, input int exp_rises);
    int run = 0, best = 0, rises = 0;
    @(posedge clk_in);
    lw <= 0;
    repeat (240) begin
      tick();
      rises += (low_side_gate_out === 1'b1 && run == 0);
      run = (low_side_gate_out === 1'b1) ? run + 1 : 0;
      best = (run > best) ? run : best;
    end
    compare({7'h0, best >= exp_min && best <= exp_max}, 8'h01);
    compare({7'h0, rises >= exp_rises}, 8'h01);
  endtask
  task automatic disabled();
    @(posedge clk_in);
    enable_pin_in <= 1'b0;
    setting_q <= 8'hc0;
    repeat (8) @(posedge clk_in);
    enable_pin_in <= 1'b1;
    wait_reg(1'b1, 2000);
    compare({7'h0, trip_dac_out >= 8'hc0 && trip_dac_out <= 8'hc3}, 8'h01);
    compare({7'h0, guard_off_out}, 8'h01);
    stretch(0, 0, 0);
    compare({7'h0, low_side_gate_out}, 8'h00);
    @(posedge clk_in);
    lw <= 10;
    short_q <= 1'b1;
    repeat (200) tick();
    compare({7'h0, regulating_out}, 8'h01);
  endtask
  task automatic final_report();
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence; retries take about thirteen hundred cycles, so the limit below is generous.
  initial begin
    start_up(8'h40);
    hiccup();
    stretch(MIN_PULSE_CYC, MIN_PULSE_CYC + 1, 3);
    disabled();
    final_report();
  end
  initial begin
    repeat (40000) @(posedge clk_in);
    error_cnt++;
    final_report();
  end
endmodule
bind overcurrent_guard guard_asserts #(.DELAY_CYC(DELAY_CYC), .SAMPLE_CYC(SAMPLE_CYC), .STEP_LEN(STEP_LEN))
  guard_asserts_inst (.clk_in, .rst_n_in, .low_side_gate_out, .high_side_gate_out, .source_en_out,
  .trip_dac_out, .ramp_step_out, .guard_off_out, .regulating_out);
